// ### design/dcd_top.sv
// Debug command decoder: command gating, replies, control register, runtime counter
`timescale 1ns/10ps
module dcd_top
	import dcd_pkg::*;
#(
	parameter logic [15:0] DEBUGGER_REVISION = 16'h0100, // Arbitrary value
	parameter int          FIFO_DEPTH        = TX_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// Received command and parameter bytes
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_data_in,
	output logic             rx_ready_out,
	// Reply bytes towards the serial transmitter
	output logic             tx_valid_out,
	output logic [7:0]       tx_data_out,
	input  wire logic        tx_ready_in,
	// Serial error handling
	input  wire logic        serial_err_in,
	output logic             break_req_out,
	output logic             baud_reset_out,
	// Device state
	input  wire logic        read_protect_option_in,
	input  wire logic [7:0]  debugger_status_reg_in,
	input  wire logic        brk_decoded_in,
	input  wire logic        reset_done_in,
	output logic [7:0]       debugger_control_reg_out,
	output logic [15:0]      runtime_count_out,
	// Processor program counter
	input  wire logic [15:0] pc_in,
	output logic             pc_wr_out,
	output logic [15:0]      pc_data_out,
	// Execution-side commands
	output logic             ext_start_out,
	output dcd_ext_type      ext_info_out,
	output logic             ext_byte_valid_out,
	output logic [7:0]       ext_byte_out,
	input  wire logic        ext_done_in
);
	// Reset synchroniser
	logic          rst_s1_r;
	logic          rst_s2_r;
	logic          rst_n;
	// Decoder state
	dcd_state_type state_r;
	dcd_state_type state_nxt;
	logic [7:0]    ctl_r;
	logic [15:0]   rtc_r;
	logic          dbg_d_r;
	logic          dbg_s_r;
	logic          prot_s_r;
	logic [7:0]    pc_hi_r;
	logic [15:0]   resp_r;
	logic          resp_two_r;
	// Decode helpers
	logic          rx_fire;
	logic          dbg_now;
	logic          norm_ok;
	logic          is_ext;
	logic          ext_bar;
	logic          resp_ld;
	logic [15:0]   resp_val;
	logic          resp_two;
	// FIFO wiring
	logic          fifo_in_ready;
	logic          fifo_push;
	logic          fifo_out_valid;
	logic          fifo_out_ready;
	logic [7:0]    fifo_out_data;
	logic          tx_valid_r;
	logic [7:0]    tx_data_r;
	logic          rx_ready_r;

	// Release reset through two flip-flops
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_s2_r;

	// Byte handshake and live gating terms
	assign rx_fire   = rx_valid_in && rx_ready_r;
	assign dbg_now   = ctl_r[CTL_DBG_BIT];
	assign fifo_push = (state_r == ST_RESP) && fifo_in_ready;
	assign norm_ok   = (rx_data_in == CMD_REV) || (rx_data_in == CMD_STAT) ||
	                   (rx_data_in == CMD_CTLW) || (rx_data_in == CMD_CTLR);
	assign is_ext    = (rx_data_in >= CMD_EXT_LO) && (rx_data_in <= CMD_EXT_HI) &&
	                   (rx_data_in != CMD_RSVD);
	// Barred when outside debug, or protected and not among the unprotected ones
	assign ext_bar   = !dbg_now || (read_protect_option_in && (rx_data_in != CMD_REGW) &&
	                   (rx_data_in != CMD_RDDM) && (rx_data_in != CMD_CRC));

	// Next state and reply selection
	always_comb begin
		state_nxt = state_r;
		resp_ld   = 1'b0;
		resp_val  = 16'h0000;
		resp_two  = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (rx_fire) begin
					if (dbg_now || norm_ok) begin
						unique case (rx_data_in)
							CMD_REV: begin
								resp_ld  = 1'b1;
								resp_val = DEBUGGER_REVISION;
								resp_two = 1'b1;
							end
							CMD_STAT: begin
								resp_ld  = 1'b1;
								resp_val = {debugger_status_reg_in, 8'h00};
							end
							CMD_RTC: begin
								resp_ld  = 1'b1;
								resp_val = rtc_r;
								resp_two = 1'b1;
							end
							CMD_CTLR: begin
								resp_ld  = 1'b1;
								resp_val = {ctl_r, 8'h00};
							end
							CMD_CTLW: state_nxt = ST_CTL;
							CMD_PCW:  state_nxt = ST_PCH;
							CMD_PCR: begin
								resp_ld  = 1'b1;
								resp_val = read_protect_option_in ? PC_FILL : pc_in;
								resp_two = 1'b1;
							end
							default: state_nxt = is_ext ? ST_EXT : ST_IDLE;
						endcase
					end else if (rx_data_in == CMD_PCW) begin
						state_nxt = ST_PCH;
					end else if (rx_data_in == CMD_PCR) begin
						resp_ld  = 1'b1;
						resp_val = PC_FILL;
						resp_two = 1'b1;
					end else if (is_ext) begin
						state_nxt = ST_EXT;
					end
					if (resp_ld) begin
						state_nxt = ST_RESP;
					end
				end
			end
			ST_CTL: begin
				if (rx_fire) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_PCH: begin
				if (rx_fire) begin
					state_nxt = ST_PCL;
				end
			end
			ST_PCL: begin
				if (rx_fire) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_RESP: begin
				if (fifo_push && !resp_two_r) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_EXT: begin
				if (ext_done_in) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (serial_err_in) begin
			state_nxt = ST_IDLE;
		end
	end

	// State register and byte acceptance
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ST_IDLE;
			rx_ready_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			rx_ready_r <= (state_nxt != ST_RESP);
		end
	end

	// Gating conditions caught at the command byte
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dbg_s_r  <= 1'b0;
			prot_s_r <= 1'b0;
		end else if ((state_r == ST_IDLE) && rx_fire) begin
			dbg_s_r  <= dbg_now;
			prot_s_r <= read_protect_option_in;
		end
	end

	// Reply shift register, high byte first
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			resp_r     <= 16'h0000;
			resp_two_r <= 1'b0;
		end else if (resp_ld && !serial_err_in) begin
			resp_r     <= resp_val;
			resp_two_r <= resp_two;
		end else if (fifo_push) begin
			resp_r     <= {resp_r[7:0], 8'h00};
			resp_two_r <= 1'b0;
		end
	end

	// Debugger control register
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= CTL_RESET;
		end else begin
			if ((state_r == ST_CTL) && rx_fire && !serial_err_in) begin
				ctl_r <= rx_data_in & CTL_WR_MASK;
				if (prot_s_r && ctl_r[CTL_DBG_BIT]) begin
					ctl_r[CTL_DBG_BIT] <= 1'b1;
				end
			end else if (reset_done_in) begin
				ctl_r[CTL_RST_BIT] <= 1'b0;
			end
			// A breakpoint wins over a clearing write
			if (brk_decoded_in && ctl_r[CTL_BRKEN_BIT]) begin
				ctl_r[CTL_DBG_BIT] <= 1'b1;
			end
		end
	end

	// Runtime counter
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rtc_r   <= RTC_START;
			dbg_d_r <= 1'b0;
		end else begin
			dbg_d_r <= dbg_now;
			if ((state_r == ST_IDLE) && (state_nxt == ST_EXT) && !ext_bar) begin
				rtc_r <= RTC_START;
			end else if (dbg_d_r && !dbg_now) begin
				rtc_r <= RTC_START;
			end else if (!dbg_now && (rtc_r != RTC_MAX)) begin
				rtc_r <= rtc_r + 16'h0001;
			end
		end
	end

	// Program counter load
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pc_hi_r     <= 8'h00;
			pc_wr_out   <= 1'b0;
			pc_data_out <= 16'h0000;
		end else begin
			pc_wr_out <= 1'b0;
			if ((state_r == ST_PCH) && rx_fire) begin
				pc_hi_r <= rx_data_in;
			end
			if ((state_r == ST_PCL) && rx_fire && !serial_err_in &&
			    dbg_s_r && !prot_s_r) begin
				pc_wr_out   <= 1'b1;
				pc_data_out <= {pc_hi_r, rx_data_in};
			end
		end
	end

	// Hand-off of execution-side commands and their bytes
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ext_start_out      <= 1'b0;
			ext_info_out       <= '0;
			ext_byte_valid_out <= 1'b0;
			ext_byte_out       <= 8'h00;
		end else begin
			ext_start_out      <= 1'b0;
			ext_byte_valid_out <= 1'b0;
			if ((state_r == ST_IDLE) && (state_nxt == ST_EXT)) begin
				ext_start_out          <= 1'b1;
				ext_info_out.cmd       <= rx_data_in;
				ext_info_out.discard   <= ext_bar;
				ext_info_out.reg_limit <= read_protect_option_in &&
				                          (rx_data_in == CMD_REGW);
			end
			if ((state_r == ST_EXT) && rx_fire && !serial_err_in) begin
				ext_byte_valid_out <= 1'b1;
				ext_byte_out       <= rx_data_in;
			end
		end
	end

	// Error reaction towards the serial layer
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			break_req_out  <= 1'b0;
			baud_reset_out <= 1'b0;
		end else begin
			break_req_out  <= serial_err_in;
			baud_reset_out <= serial_err_in;
		end
	end

	// Reply FIFO, flushed on a serial error
	dcd_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (sys_clk_in),
		.rst_n_in      (rst_n),
		.flush_in      (serial_err_in),
		.in_valid_in   (fifo_push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (resp_r[15:8]),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	// Output stage; the serializer frames each byte LSB first
	assign fifo_out_ready = !tx_valid_r || tx_ready_in;
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
		end else if (serial_err_in) begin
			tx_valid_r <= 1'b0;
		end else if (fifo_out_ready) begin
			tx_valid_r <= fifo_out_valid;
			tx_data_r  <= fifo_out_data;
		end
	end

	// Ports driven from flip-flops
	assign tx_valid_out             = tx_valid_r;
	assign tx_data_out              = tx_data_r;
	assign rx_ready_out             = rx_ready_r;
	assign debugger_control_reg_out = ctl_r;
	assign runtime_count_out        = rtc_r;
endmodule

// ### design/dcd_pkg.sv
// Shared constants and types of the debug command decoder
package dcd_pkg;
	// Command bytes
	localparam logic [7:0] CMD_REV    = 8'h00;
	localparam logic [7:0] CMD_STAT   = 8'h02;
	localparam logic [7:0] CMD_RTC    = 8'h03;
	localparam logic [7:0] CMD_CTLW   = 8'h04;
	localparam logic [7:0] CMD_CTLR   = 8'h05;
	localparam logic [7:0] CMD_PCW    = 8'h06;
	localparam logic [7:0] CMD_PCR    = 8'h07;
	localparam logic [7:0] CMD_REGW   = 8'h08;
	localparam logic [7:0] CMD_RDDM   = 8'h0D;
	localparam logic [7:0] CMD_CRC    = 8'h0E;
	localparam logic [7:0] CMD_RSVD   = 8'h0F;
	localparam logic [7:0] CMD_EXT_LO = 8'h08;
	localparam logic [7:0] CMD_EXT_HI = 8'h12;
	// Control register layout and reset value
	localparam int         CTL_DBG_BIT   = 7;
	localparam int         CTL_BRKEN_BIT = 6;
	localparam int         CTL_RST_BIT   = 0;
	localparam logic [7:0] CTL_WR_MASK   = 8'hE1;
	localparam logic [7:0] CTL_RESET     = 8'h00;
	// Runtime counter and fill values
	localparam logic [15:0] RTC_START = 16'h0000;
	localparam logic [15:0] RTC_MAX   = 16'hFFFF;
	localparam logic [15:0] PC_FILL   = 16'hFFFF;
	// Response FIFO size
	localparam int TX_FIFO_DEPTH = 8;
	// Decoder states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CTL  = 6'h02,
		ST_PCH  = 6'h04,
		ST_PCL  = 6'h08,
		ST_RESP = 6'h10,
		ST_EXT  = 6'h20
	} dcd_state_type;
	// Hand-off of a memory, register or step command to the execution side
	typedef struct packed {
		logic       discard;
		logic       reg_limit;
		logic [7:0] cmd;
	} dcd_ext_type;
endpackage

// ### design/dcd_fifo.sv
// Response byte FIFO with valid and ready on both sides
`timescale 1ns/10ps
module dcd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             flush_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem_r[rd_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_r] <= in_data_in;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else if (flush_in) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### design/dcd_readme_none.sv
// Intentionally empty compilation unit
`timescale 1ns/10ps

// ### verif/dcd_chk.sv
// Port-level checks of the debug command decoder
`timescale 1ns/10ps
module dcd_chk
	import dcd_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	// Reply stream and serial errors
	input wire logic        tx_valid_out,
	input wire logic [7:0]  tx_data_out,
	input wire logic        tx_ready_in,
	input wire logic        serial_err_in,
	input wire logic        break_req_out,
	input wire logic        baud_reset_out,
	// Device state and hand-offs
	input wire logic        read_protect_option_in,
	input wire logic [7:0]  debugger_control_reg_out,
	input wire logic [15:0] runtime_count_out,
	input wire logic        pc_wr_out,
	input wire logic        ext_start_out,
	input wire dcd_ext_type ext_info_out
);
	logic [1:0] up_r;
	wire        c7 = debugger_control_reg_out[7];
	wire        ok = (up_r == 2'h3);
	// Skips the edges where the reset synchroniser still holds the block
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			up_r <= 2'h0;
		else if (!ok)
			up_r <= up_r + 2'h1;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	err_break_a: assert property (serial_err_in |=> break_req_out && baud_reset_out)
		else $error("break request missing after serial error");
	err_quiet_a: assert property (!serial_err_in |=> !break_req_out)
		else $error("break request without serial error");
	rtc_count_a: assert property (ok && !c7 && !$past(c7) && !$past(c7, 2)
		&& runtime_count_out != 16'hFFFF |=> runtime_count_out == $past(runtime_count_out) + 16'h1)
		else $error("runtime counter did not step");
	rtc_sat_a: assert property (ok && !c7 && !$past(c7) && !$past(c7, 2)
		&& runtime_count_out == 16'hFFFF |=> runtime_count_out == 16'hFFFF)
		else $error("runtime counter wrapped");
	rtc_hold_a: assert property (c7 |=> $stable(runtime_count_out) || runtime_count_out == 16'h0)
		else $error("runtime counter moved in debug mode");
	rtc_restart_a: assert property ($fell(c7) |-> ##[0:1] runtime_count_out == 16'h0)
		else $error("runtime counter not restarted");
	dbg_keep_a: assert property (read_protect_option_in && c7 |=> c7)
		else $error("debug bit cleared under protection");
	pc_gate_a: assert property (pc_wr_out |-> c7 && !read_protect_option_in)
		else $error("program counter written while barred");
	ext_discard_a: assert property (ext_start_out && (!c7 || (read_protect_option_in
		&& !(ext_info_out.cmd inside {8'h08, 8'h0D, 8'h0E}))) |-> ext_info_out.discard)
		else $error("barred command not discarded");
	ext_limit_a: assert property (ext_start_out && c7 && read_protect_option_in
		&& ext_info_out.cmd == 8'h08 |-> ext_info_out.reg_limit && !ext_info_out.discard)
		else $error("protected register write not limited");
	tx_stand_a: assert property (tx_valid_out && !tx_ready_in && !serial_err_in
		|=> tx_valid_out && $stable(tx_data_out))
		else $error("reply byte dropped before taken");
endmodule
bind dcd_top dcd_chk u_chk (.sys_clk_in, .rst_n_in, .tx_valid_out, .tx_data_out, .tx_ready_in,
	.serial_err_in, .break_req_out, .baud_reset_out, .read_protect_option_in,
	.debugger_control_reg_out, .runtime_count_out, .pc_wr_out, .ext_start_out, .ext_info_out);

// ### verif/dcd_host_model.sv
// Host-side reply sink: takes reply bytes promptly or with stalls
`timescale 1ns/10ps
module dcd_host_model (
	// Clock
	input  wire logic       sys_clk_in,
	// Reply stream from the decoder
	input  wire logic       tx_valid_out,
	input  wire logic [7:0] tx_data_out,
	output logic            tx_ready_in,
	// Stall request from the bench
	input  wire logic       slow_in
);
	logic [7:0] rx_q[$];
	logic       take;
	logic [7:0] seen;
	initial tx_ready_in = 1'b1;
	// Samples between edges so the capture never races the decoder
	always @(negedge sys_clk_in) begin
		take = tx_valid_out && tx_ready_in;
		seen = tx_data_out;
	end
	// Stores each byte taken at the previous falling edge; ready toggles while stalled
	always @(posedge sys_clk_in) begin
		if (take)
			rx_q.push_back(seen);
		tx_ready_in <= slow_in ? ~tx_ready_in : 1'b1;
	end
endmodule

// ### verif/debug_command_decoder_tb_top.sv
// Self-checking testbench of the debug command decoder
`timescale 1ns/10ps
module debug_command_decoder_tb_top;
	import dcd_pkg::*;
	localparam logic [15:0] REV = 16'h0123; // Arbitrary revision value
	logic sys_clk_in = 1'b0, rst_n_in = 1'b0, rx_valid_in = 1'b0, serial_err_in = 1'b0;
	logic read_protect_option_in = 1'b0, brk_decoded_in = 1'b0, reset_done_in = 1'b0;
	logic ext_done_in = 1'b0, slow = 1'b0, pc_seen, ext_seen, brk_seen;
	logic [7:0] rx_data_in = 8'h00, debugger_status_reg_in = 8'h5A;
	logic [15:0] pc_in = 16'hBEEF;
	logic rx_ready_out, tx_valid_out, tx_ready_in, break_req_out, baud_reset_out, pc_wr_out;
	logic ext_start_out, ext_byte_valid_out, byte_seen;
	logic [7:0] ext_byte_out;
	logic [7:0] tx_data_out, debugger_control_reg_out;
	logic [15:0] runtime_count_out, pc_data_out;
	dcd_ext_type ext_info_out;
	int failures = 0, total_checks = 0, cyc = 0;
	dcd_top #(.DEBUGGER_REVISION(REV)) u_dut (.sys_clk_in, .rst_n_in, .rx_valid_in, .rx_data_in,
		.rx_ready_out, .tx_valid_out, .tx_data_out, .tx_ready_in, .serial_err_in, .break_req_out,
		.baud_reset_out, .read_protect_option_in, .debugger_status_reg_in, .brk_decoded_in,
		.reset_done_in, .debugger_control_reg_out, .runtime_count_out, .pc_in, .pc_wr_out,
		.pc_data_out, .ext_start_out, .ext_info_out, .ext_byte_valid_out, .ext_byte_out,
		.ext_done_in);
	dcd_host_model u_host (.sys_clk_in, .tx_valid_out, .tx_data_out, .tx_ready_in, .slow_in(slow));
	// Clock and hang guard
	always #10 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			give_verdict();
		end
	end
	// Remembers one-cycle pulses between edges
	always @(negedge sys_clk_in) begin
		if (pc_wr_out === 1'b1) pc_seen = 1'b1;
		if (ext_start_out === 1'b1) ext_seen = 1'b1;
		if (ext_byte_valid_out === 1'b1) byte_seen = 1'b1;
		if (break_req_out === 1'b1 && baud_reset_out === 1'b1) brk_seen = 1'b1;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic do_reset();
		rst_n_in <= 1'b0;
		tick(2);
		rst_n_in <= 1'b1;
		tick(4);
	endtask
	// Offers one byte and holds it until the decoder takes it
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		rx_valid_in <= 1'b1;
		rx_data_in <= b;
		@(negedge sys_clk_in);
		while (rx_ready_out !== 1'b1 && n < 60) begin
			n++;
			@(negedge sys_clk_in);
		end
		@(posedge sys_clk_in);
		rx_valid_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	// Command, its parameters, then n reply bytes gathered high byte first
	task automatic cmd(input logic [7:0] c, input int np, input logic [15:0] p, input int n,
		output logic [15:0] r);
		int k;
		u_host.rx_q.delete();
		pc_seen = 1'b0;
		send(c);
		if (np == 2) send(p[15:8]);
		if (np > 0) send(p[7:0]);
		for (k = 0; k < 80 && u_host.rx_q.size() < n; k++) tick(1);
		tick(6);
		chk("reply count", 16'(u_host.rx_q.size()), 16'(n));
		r = 16'h0;
		foreach (u_host.rx_q[i]) r = {r[7:0], u_host.rx_q[i]};
	endtask
	// Execution-side command: hand-off flags, then completion
	task automatic ext(input logic [7:0] c, input logic d, input logic l);
		ext_seen = 1'b0;
		send(c);
		tick(2);
		chk("handoff", {15'h0, ext_seen}, 16'h1);
		chk("handoff flags", {6'h0, ext_info_out}, {6'h0, d, l, c});
		// A parameter byte is passed on to the execution side
		byte_seen = 1'b0;
		send(8'hA5);
		chk("ext byte", {byte_seen, 7'h00, ext_byte_out}, 16'h80A5);
		ext_done_in <= 1'b1;
		tick(1);
		ext_done_in <= 1'b0;
		tick(2);
	endtask
	task automatic t_normal();
		logic [15:0] r, a;
		logic [7:0] barred [5] = '{8'h01, CMD_RTC, CMD_RSVD, 8'h13, 8'hFF};
		cmd(CMD_REV, 0, 16'h0, 2, r);
		chk("revision", r, REV);
		cmd(CMD_STAT, 0, 16'h0, 1, r);
		chk("status", r, 16'h005A);
		cmd(CMD_CTLR, 0, 16'h0, 1, r);
		chk("control read", r, 16'h0000);
		foreach (barred[i])
			cmd(barred[i], 0, 16'h0, 0, r);
		cmd(CMD_PCR, 0, 16'h0, 2, r);
		chk("pc fill", r, 16'hFFFF);
		cmd(CMD_PCW, 2, 16'h1234, 0, r);
		chk("pc write barred", {15'h0, pc_seen}, 16'h0);
		ext(8'h0A, 1'b1, 1'b0);
		@(negedge sys_clk_in);
		a = runtime_count_out;
		repeat (10) @(negedge sys_clk_in);
		chk("count step", runtime_count_out - a, 16'h000A);
		// Back onto the rising edge before the next stimulus
		@(posedge sys_clk_in);
	endtask
	task automatic t_debug();
		logic [15:0] r, a;
		cmd(CMD_CTLW, 1, 16'h00FF, 0, r);
		chk("control write", {8'h0, debugger_control_reg_out}, 16'h00E1);
		reset_done_in <= 1'b1;
		tick(1);
		reset_done_in <= 1'b0;
		tick(2);
		a = runtime_count_out;
		cmd(CMD_CTLR, 0, 16'h0, 1, r);
		chk("control after reset", r, 16'h00E0);
		chk("count held", runtime_count_out, a);
		cmd(CMD_PCR, 0, 16'h0, 2, r);
		chk("pc read", r, 16'hBEEF);
		cmd(CMD_PCW, 2, 16'h1234, 0, r);
		chk("pc written", {15'h0, pc_seen}, 16'h1);
		chk("pc data", pc_data_out, 16'h1234);
		ext(8'h09, 1'b0, 1'b0);
		slow <= 1'b1;
		cmd(CMD_REV, 0, 16'h0, 2, r);
		chk("slow revision", r, REV);
		brk_seen = 1'b0;
		send(CMD_REV);
		serial_err_in <= 1'b1;
		tick(1);
		serial_err_in <= 1'b0;
		slow <= 1'b0;
		tick(8);
		chk("break back", {15'h0, brk_seen}, 16'h1);
		cmd(CMD_CTLR, 0, 16'h0, 1, r);
		chk("control kept", r, 16'h00E0);
		cmd(CMD_CTLW, 1, 16'h0040, 0, r);
		brk_decoded_in <= 1'b1;
		tick(1);
		brk_decoded_in <= 1'b0;
		tick(2);
		chk("breakpoint", {8'h0, debugger_control_reg_out}, 16'h00C0);
	endtask
	task automatic t_protect();
		logic [15:0] r;
		read_protect_option_in <= 1'b1;
		tick(1);
		cmd(CMD_PCR, 0, 16'h0, 2, r);
		chk("protected pc", r, 16'hFFFF);
		cmd(CMD_PCW, 2, 16'h5678, 0, r);
		chk("protected pc write", {15'h0, pc_seen}, 16'h0);
		cmd(CMD_CTLW, 1, 16'h0000, 0, r);
		chk("debug kept", {8'h0, debugger_control_reg_out}, 16'h0080);
		ext(8'h09, 1'b1, 1'b0);
		ext(8'h10, 1'b1, 1'b0);
		ext(CMD_REGW, 1'b0, 1'b1);
		ext(CMD_RDDM, 1'b0, 1'b0);
		cmd(CMD_STAT, 0, 16'h0, 1, r);
		chk("protected status", r, 16'h005A);
		read_protect_option_in <= 1'b0;
		do_reset();
		chk("reset leaves debug", {8'h0, debugger_control_reg_out}, 16'h0000);
	endtask
	task automatic t_saturate();
		logic [15:0] r;
		tick(65540);
		chk("count saturates", runtime_count_out, 16'hFFFF);
		cmd(CMD_CTLW, 1, 16'h0080, 0, r);
		cmd(CMD_RTC, 0, 16'h0, 2, r);
		chk("count read", r, 16'hFFFF);
	endtask
	initial begin
		do_reset();
		t_normal();
		t_debug();
		t_protect();
		t_saturate();
		give_verdict();
	end
endmodule
